// file: src/mcuseq_pkg.sv
package mcuseq_pkg;

    // widths of the sequencer datapath
    localparam int unsigned IP_W = 13;
    localparam int unsigned BANK_W = 3;
    localparam int unsigned ROM_AW = 16;
    localparam int unsigned WAVE_AW = 17;
    localparam int unsigned SAMPLE_W = 12;
    localparam int unsigned SAMPLE_SHIFT = 5;
    localparam int unsigned WORD_W = 16;
    localparam int unsigned PADDR_W = 12;

    // clock division and phase count
    localparam int unsigned SYS_DIV = 2;
    localparam int unsigned PHASES = 4;
    localparam logic [3:0] PHASE_RST = 4'h1;

    // register indices; byte address is four times the index
    localparam logic [7:0] IPL_IDX = 8'h06;
    localparam logic [7:0] BANK_IDX = 8'h08;
    localparam logic [7:0] STAT_IDX = 8'h09;
    localparam logic [7:0] CTRL_IDX = 8'h0a;

    // status and control register field positions
    localparam int unsigned STAT_IP_LSB = 0;
    localparam int unsigned STAT_BANK_LSB = 13;
    localparam int unsigned STAT_DUMMY_BIT = 16;
    localparam int unsigned STAT_BPEND_BIT = 17;
    localparam int unsigned CTRL_RUN_BIT = 0;

    // reset values, vectors and bank write delay
    localparam logic [IP_W-1:0] VEC_RESET = 13'h0000;
    localparam logic [IP_W-1:0] VEC_TMR0 = 13'h0008;
    localparam logic [IP_W-1:0] VEC_TMR1 = 13'h000c;
    localparam logic [BANK_W-1:0] BANK_RST = 3'h0;
    localparam logic CTRL_RUN_RST = 1'b1;
    localparam logic [1:0] BANK_DELAY = 2'h2;

    // operation reported by the decoder for the executing word
    typedef enum logic [4:0] {
        MCUSEQ_OP_NONE = 5'b00001,
        MCUSEQ_OP_JUMP = 5'b00010,
        MCUSEQ_OP_CALL = 5'b00100,
        MCUSEQ_OP_RET = 5'b01000,
        MCUSEQ_OP_SKIP = 5'b10000
    } mcuseq_op_t;

    typedef struct packed {
        mcuseq_op_t op;
        logic [IP_W-1:0] target;
    } mcuseq_exec_t;

    typedef struct packed {
        logic push;
        logic [IP_W-1:0] addr;
    } mcuseq_push_t;

endpackage : mcuseq_pkg

// file: src/mcuseq_phase.sv
module mcuseq_phase (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic run,
    // timing outputs
    output logic sys_en,
    output logic [3:0] phase
);

    logic div_r;
    logic sys_en_r;
    logic [3:0] phase_r;

    // oscillator divided by two gives the system clock enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_r <= 1'b0;
            sys_en_r <= 1'b0;
        end else begin
            div_r <= (div_r == 1'(mcuseq_pkg::SYS_DIV - 1)) ? 1'b0 : 1'b1;
            sys_en_r <= div_r;
        end
    end

    // four non-overlapping phases make one instruction cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_r <= mcuseq_pkg::PHASE_RST;
        end else if (sys_en_r && run) begin
            phase_r <= {phase_r[2:0], phase_r[3]};
        end
    end

    assign sys_en = sys_en_r;
    assign phase = phase_r;

endmodule : mcuseq_phase

// file: src/mcuseq_top.sv
// Operation
// - system clock is oscillator divided by two
// - instruction cycle is four system phases
// - fetch one cycle, execute the next
// - pointer-changing instructions take two cycles
// - instruction pointer is thirteen bits wide
// - pointer increments after each fetch
// - taken skip discards prefetch, inserts dummy
// - low byte readable; write is short jump
// - pointer loads on transfers; reset clears all but run
// - first timer interrupt vectors to 0x008
// - second timer interrupt vectors to 0x00c
// - jump and call take code bits, bank
// - return restores stack bits, keeps bank
// - program address is bank then pointer
// - wavetable address is sample start shifted five
// - one shared sixteen-bit ROM address bus
// - timer vectors stay in current bank
// - bank write lands after following instruction
module mcuseq_top (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // decoder and stack side
    input wire mcuseq_pkg::mcuseq_exec_t exec_in,
    input wire logic [12:0] pop_addr,
    input wire logic tmr0_ack,
    input wire logic tmr1_ack,
    output mcuseq_pkg::mcuseq_push_t push_out,
    output logic [1:0] int_taken,
    output logic [15:0] instr_word,
    output logic instr_valid,
    output logic [3:0] phase,
    // wavetable request
    input wire logic wave_req,
    input wire logic [11:0] sample_start_address,
    output logic [15:0] wave_data,
    output logic wave_valid,
    // rom
    output logic [15:0] rom_address_lines,
    output logic rom_wave_sel,
    input wire logic [15:0] rom_data
);

    logic sys_en;
    logic [3:0] phase_w;
    logic cycle_end;
    logic fetch_end;

    logic [12:0] instruction_pointer_r;
    logic [12:0] ip_nxt;
    logic [12:0] ip_inc;
    logic flush_nxt;
    logic push_nxt;
    logic [1:0] int_nxt;

    logic [2:0] bank_select_r;
    logic [2:0] bank_wdata_r;
    logic [1:0] bank_cnt_r;
    logic pcl_pend_r;
    logic [7:0] pcl_data_r;
    logic run_r;

    logic [15:0] fetch_word_r;
    logic [15:0] instr_r;
    logic instr_valid_r;
    mcuseq_pkg::mcuseq_push_t push_r;
    logic [1:0] int_taken_r;

    logic [15:0] rom_addr_r;
    logic rom_wave_r;
    logic [15:0] wave_data_r;
    logic wave_valid_r;

    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic apb_setup;
    logic apb_wr;

    // byte address of a register index
    function automatic logic [11:0] reg_addr(input logic [7:0] idx);
        reg_addr = {2'b00, idx, 2'b00};
    endfunction : reg_addr

    // program fetch address
    function automatic logic [15:0] prog_addr(input logic [2:0] bank,
                                              input logic [12:0] ip);
        prog_addr = {bank, ip};
    endfunction : prog_addr

    // wavetable address, upper bit beyond the bus is dropped
    function automatic logic [15:0] wave_addr(input logic [11:0] st);
        logic [16:0] full;
        full = {st, 5'h00};
        wave_addr = full[15:0];
    endfunction : wave_addr

    mcuseq_phase u_phase (
        .pclk(pclk),
        .presetn(presetn),
        .run(run_r),
        .sys_en(sys_en),
        .phase(phase_w)
    );

    assign cycle_end = sys_en && run_r && phase_w[3];
    assign fetch_end = sys_en && run_r && phase_w[1];
    assign ip_inc = instruction_pointer_r + 13'h0001;

    // next pointer; executing transfers beat a pending short jump
    always_comb begin
        ip_nxt = ip_inc;
        flush_nxt = 1'b0;
        push_nxt = 1'b0;
        int_nxt = 2'b00;
        if (instr_valid_r && exec_in.op == mcuseq_pkg::MCUSEQ_OP_JUMP) begin
            ip_nxt = exec_in.target;
            flush_nxt = 1'b1;
        end else if (instr_valid_r &&
                     exec_in.op == mcuseq_pkg::MCUSEQ_OP_CALL) begin
            ip_nxt = exec_in.target;
            flush_nxt = 1'b1;
            push_nxt = 1'b1;
        end else if (instr_valid_r &&
                     exec_in.op == mcuseq_pkg::MCUSEQ_OP_RET) begin
            ip_nxt = pop_addr;
            flush_nxt = 1'b1;
        end else if (instr_valid_r &&
                     exec_in.op == mcuseq_pkg::MCUSEQ_OP_SKIP) begin
            // prefetched word is dropped, pointer already past it
            ip_nxt = ip_inc;
            flush_nxt = 1'b1;
        end else if (pcl_pend_r) begin
            ip_nxt = {instruction_pointer_r[12:8], pcl_data_r};
            flush_nxt = 1'b1;
        end else if (tmr0_ack) begin
            ip_nxt = mcuseq_pkg::VEC_TMR0;
            flush_nxt = 1'b1;
            push_nxt = 1'b1;
            int_nxt = 2'b01;
        end else if (tmr1_ack) begin
            ip_nxt = mcuseq_pkg::VEC_TMR1;
            flush_nxt = 1'b1;
            push_nxt = 1'b1;
            int_nxt = 2'b10;
        end
    end

    // instruction pointer; reset lands at address zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            instruction_pointer_r <= mcuseq_pkg::VEC_RESET;
        end else if (cycle_end) begin
            instruction_pointer_r <= ip_nxt;
        end
    end

    // fetch word captured mid-cycle, before a wave access reuses the bus
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fetch_word_r <= 16'h0000;
        end else if (fetch_end) begin
            fetch_word_r <= rom_data;
        end
    end

    // fetched word moves to execute; a transfer turns it into a dummy
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            instr_r <= 16'h0000;
            instr_valid_r <= 1'b0;
        end else if (cycle_end) begin
            instr_r <= fetch_word_r;
            instr_valid_r <= !flush_nxt;
        end
    end

    // return address is the word being fetched, not yet executed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            push_r <= '0;
            int_taken_r <= 2'b00;
        end else if (cycle_end) begin
            push_r.push <= push_nxt;
            push_r.addr <= instruction_pointer_r;
            int_taken_r <= int_nxt;
        end else begin
            push_r.push <= 1'b0;
            int_taken_r <= 2'b00;
        end
    end

    // pending short jump, held until an instruction boundary
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pcl_pend_r <= 1'b0;
            pcl_data_r <= 8'h00;
        end else if (apb_wr && paddr == reg_addr(mcuseq_pkg::IPL_IDX)) begin
            pcl_pend_r <= 1'b1;
            pcl_data_r <= pwdata[7:0];
        end else if (cycle_end && ip_nxt[7:0] == pcl_data_r &&
                     !(instr_valid_r &&
                       exec_in.op != mcuseq_pkg::MCUSEQ_OP_NONE)) begin
            pcl_pend_r <= 1'b0;
        end
    end

    // bank change counts two boundaries: writer, then the next one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bank_select_r <= mcuseq_pkg::BANK_RST;
            bank_wdata_r <= mcuseq_pkg::BANK_RST;
            bank_cnt_r <= 2'h0;
        end else if (apb_wr && paddr == reg_addr(mcuseq_pkg::BANK_IDX)) begin
            bank_wdata_r <= pwdata[2:0];
            bank_cnt_r <= mcuseq_pkg::BANK_DELAY;
        end else if (cycle_end && bank_cnt_r != 2'h0) begin
            bank_cnt_r <= bank_cnt_r - 2'h1;
            if (bank_cnt_r == 2'h1) begin
                bank_select_r <= bank_wdata_r;
            end
        end
    end

    // run control
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_r <= mcuseq_pkg::CTRL_RUN_RST;
        end else if (apb_wr && paddr == reg_addr(mcuseq_pkg::CTRL_IDX)) begin
            run_r <= pwdata[mcuseq_pkg::CTRL_RUN_BIT];
        end
    end

    // shared bus: program in phases 0-1, wave in 2-3 when asked
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rom_addr_r <= 16'h0000;
            rom_wave_r <= 1'b0;
        end else if ((phase_w[2] || phase_w[3]) && wave_req) begin
            rom_addr_r <= wave_addr(sample_start_address);
            rom_wave_r <= 1'b1;
        end else begin
            // vectors use the live bank, not a forced bank zero
            rom_addr_r <= prog_addr(bank_select_r,
                                    instruction_pointer_r);
            rom_wave_r <= 1'b0;
        end
    end

    // wave data taken at the end of the cycle it was addressed in
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wave_data_r <= 16'h0000;
            wave_valid_r <= 1'b0;
        end else if (cycle_end && rom_wave_r) begin
            wave_data_r <= rom_data;
            wave_valid_r <= 1'b1;
        end else begin
            wave_valid_r <= 1'b0;
        end
    end

    assign apb_setup = psel && !penable;
    assign apb_wr = psel && penable && pwrite && pready_r && !pslverr_r;

    // registered answer: one wait-free access cycle after setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else if (apb_setup) begin
            pready_r <= 1'b1;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
            if (paddr == reg_addr(mcuseq_pkg::IPL_IDX)) begin
                prdata_r[7:0] <= instruction_pointer_r[7:0];
            end else if (paddr == reg_addr(mcuseq_pkg::BANK_IDX)) begin
                prdata_r[2:0] <= bank_select_r;
            end else if (paddr == reg_addr(mcuseq_pkg::STAT_IDX)) begin
                prdata_r[mcuseq_pkg::STAT_IP_LSB +: 13] <=
                    instruction_pointer_r;
                prdata_r[mcuseq_pkg::STAT_BANK_LSB +: 3] <= bank_select_r;
                prdata_r[mcuseq_pkg::STAT_DUMMY_BIT] <= !instr_valid_r;
                prdata_r[mcuseq_pkg::STAT_BPEND_BIT] <= bank_cnt_r != 2'h0;
                // status is read only
                pslverr_r <= pwrite;
            end else if (paddr == reg_addr(mcuseq_pkg::CTRL_IDX)) begin
                prdata_r[mcuseq_pkg::CTRL_RUN_BIT] <= run_r;
            end else begin
                pslverr_r <= 1'b1;
            end
        end else begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign push_out = push_r;
    assign int_taken = int_taken_r;
    assign instr_word = instr_r;
    assign instr_valid = instr_valid_r;
    assign phase = phase_w;
    assign rom_address_lines = rom_addr_r;
    assign rom_wave_sel = rom_wave_r;
    assign wave_data = wave_data_r;
    assign wave_valid = wave_valid_r;

endmodule : mcuseq_top

// file: verif/mcuseq_rom.sv
module mcuseq_rom (
    // clock
    input wire logic pclk,
    // shared rom address and data
    input wire logic [15:0] rom_address_lines,
    output logic [15:0] rom_data
);
    timeunit 1ns;
    timeprecision 100ps;

    // one pclk to settle, so the word seen right after a change is stale
    always_ff @(posedge pclk) begin
        rom_data <= rom_address_lines ^ 16'hc3a5;
    end
endmodule : mcuseq_rom

// file: verif/mcuseq_props.sv
module mcuseq_props (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    // sequencer
    input wire mcuseq_pkg::mcuseq_exec_t exec_in,
    input wire logic [3:0] phase,
    input wire logic [15:0] instr_word,
    input wire logic instr_valid,
    input wire logic [1:0] int_taken,
    input wire mcuseq_pkg::mcuseq_push_t push_out,
    // wave and rom
    input wire logic [11:0] sample_start_address,
    input wire logic wave_valid,
    input wire logic [15:0] rom_address_lines,
    input wire logic rom_wave_sel
);
    timeunit 1ns;
    timeprecision 100ps;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic [3:0] ph_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            ph_r <= 4'h1;
        else
            ph_r <= phase;
    end

    sequence s_end;
        phase == 4'h8 ##1 phase == 4'h1;
    endsequence
    sequence s_xfer;
        instr_valid && exec_in.op != mcuseq_pkg::MCUSEQ_OP_NONE;
    endsequence

    property p_sys_half;
        $changed(phase) |=> $stable(phase);
    endproperty
    property p_phase_rot;
        phase != ph_r |-> phase == {ph_r[2:0], ph_r[3]};
    endproperty
    property p_word_edge;
        $changed(instr_word) || $changed(instr_valid)
            |-> phase == 4'h1 && ph_r == 4'h8;
    endproperty
    property p_xfer_dummy;
        s_xfer ##0 s_end |-> !instr_valid && int_taken == 2'h0;
    endproperty
    property p_int_dummy;
        int_taken != 2'h0 |-> !instr_valid && push_out.push && ph_r == 4'h8
            ##1 int_taken == 2'h0;
    endproperty
    property p_wave_addr;
        rom_wave_sel |-> rom_address_lines ==
            {sample_start_address[10:0], 5'h00};
    endproperty
    property p_wave_pulse;
        wave_valid |-> phase == 4'h1 ##1 !wave_valid;
    endproperty
    property p_apb_ready;
        psel && !penable |=> pready ##1 !pready;
    endproperty

    a_sys_half: assert property (p_sys_half) else $error("phase short");
    a_phase_rot: assert property (p_phase_rot) else $error("phase order");
    a_word_edge: assert property (p_word_edge) else $error("word moved");
    a_xfer_dummy: assert property (p_xfer_dummy) else $error("no dummy");
    a_int_dummy: assert property (p_int_dummy) else $error("int dummy");
    a_wave_addr: assert property (p_wave_addr) else $error("wave addr");
    a_wave_pulse: assert property (p_wave_pulse) else $error("wave pulse");
    a_apb_ready: assert property (p_apb_ready) else $error("apb ready");
endmodule : mcuseq_props

bind mcuseq_top mcuseq_props u_props (.pclk, .presetn, .psel, .penable,
    .pready, .exec_in, .phase, .instr_word, .instr_valid, .int_taken,
    .push_out, .sample_start_address, .wave_valid, .rom_address_lines,
    .rom_wave_sel);

// file: verif/mcu_program_sequencer_test.sv
module mcu_program_sequencer_test;
    timeunit 1ns;
    timeprecision 100ps;

    typedef struct packed {
        mcuseq_pkg::mcuseq_op_t op;
        logic [12:0] tg;
        logic [12:0] pp;
    } mcuseq_row_t;

    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic [11:0] paddr, sample_start_address;
    logic [31:0] pwdata, prdata, s;
    mcuseq_pkg::mcuseq_exec_t exec_in;
    mcuseq_pkg::mcuseq_push_t push_out;
    logic [12:0] pop_addr, p0, ep, last_push;
    logic tmr0_ack, tmr1_ack, instr_valid, wave_req, wave_valid, rom_wave_sel;
    logic [1:0] int_taken;
    logic [3:0] phase;
    logic [15:0] instr_word, wave_data, rom_address_lines, rom_data;
    int mismatches = 0;
    int compares = 0;
    // jump lands at 1ffe so the following plain step wraps past 1fff
    mcuseq_row_t rows [6] = '{
        '{mcuseq_pkg::MCUSEQ_OP_NONE, 13'h0000, 13'h0000},
        '{mcuseq_pkg::MCUSEQ_OP_JUMP, 13'h1ffe, 13'h0000},
        '{mcuseq_pkg::MCUSEQ_OP_NONE, 13'h0000, 13'h0000},
        '{mcuseq_pkg::MCUSEQ_OP_SKIP, 13'h0000, 13'h0000},
        '{mcuseq_pkg::MCUSEQ_OP_CALL, 13'h0123, 13'h0000},
        '{mcuseq_pkg::MCUSEQ_OP_RET, 13'h0000, 13'h0456}};

    mcuseq_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .exec_in, .pop_addr, .tmr0_ack,
        .tmr1_ack, .push_out, .int_taken, .instr_word, .instr_valid, .phase,
        .wave_req, .sample_start_address, .wave_data, .wave_valid,
        .rom_address_lines, .rom_wave_sel, .rom_data);
    mcuseq_rom rom (.pclk, .rom_address_lines, .rom_data);

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    always @(negedge pclk) begin
        if (push_out.push === 1'b1)
            last_push <= push_out.addr;
    end

    task automatic end_sim;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_sim

    task automatic chk(input string n, input logic [31:0] x,
                       input logic [31:0] g);
        compares++;
        if (g !== x) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", n, x, g);
        end
    endtask : chk

    // read data and error land in s and e, taken at the ready edge
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // no wait count assumed; only the watchdog ends a hang
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        s = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // returns in the first pclk of the next instruction cycle
    task automatic bnd;
        @(negedge pclk);
        while (phase === 4'h1) begin
            @(negedge pclk);
        end
        while (phase !== 4'h1) begin
            @(negedge pclk);
        end
    endtask : bnd

    task automatic do_reset;
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        chk("reset lines", 32'h0, rom_address_lines);
        presetn <= 1'b1;
        apb(1'b0, 12'h024, 32'h0);
        chk("reset status", 32'h0, s[15:0]);
    endtask : do_reset

    initial begin
        repeat (20000) @(posedge pclk);
        mismatches++;
        end_sim();
    end

    initial begin
        int n;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        exec_in = '{mcuseq_pkg::MCUSEQ_OP_NONE, 13'h0000};
        pop_addr = 13'h0000;
        tmr0_ack = 1'b0;
        tmr1_ack = 1'b0;
        wave_req = 1'b0;
        sample_start_address = 12'h000;
        do_reset();
        for (int i = 0; i < 6; i++) begin
            bnd();
            if (instr_valid !== 1'b1)
                bnd();
            apb(1'b0, 12'h024, 32'h0);
            p0 = s[12:0];
            @(posedge pclk);
            exec_in <= '{rows[i].op, rows[i].tg};
            pop_addr <= rows[i].pp;
            case (rows[i].op)
                mcuseq_pkg::MCUSEQ_OP_JUMP: ep = rows[i].tg;
                mcuseq_pkg::MCUSEQ_OP_CALL: ep = rows[i].tg;
                mcuseq_pkg::MCUSEQ_OP_RET: ep = rows[i].pp;
                default: ep = p0 + 13'h1;
            endcase
            bnd();
            chk("valid", rows[i].op == mcuseq_pkg::MCUSEQ_OP_NONE,
                instr_valid);
            if (rows[i].op == mcuseq_pkg::MCUSEQ_OP_NONE)
                chk("word", {3'h0, p0} ^ 16'hc3a5, instr_word);
            @(posedge pclk);
            exec_in.op <= mcuseq_pkg::MCUSEQ_OP_NONE;
            apb(1'b0, 12'h024, 32'h0);
            chk("pointer", ep, s[12:0]);
            chk("lines", {3'h0, ep}, rom_address_lines);
            if (rows[i].op == mcuseq_pkg::MCUSEQ_OP_CALL)
                chk("push", p0, last_push);
        end
        apb(1'b1, 12'h020, 32'h5);
        bnd();
        apb(1'b0, 12'h024, 32'h0);
        chk("bank held", 32'h0, s[15:13]);
        chk("bank pending", 32'h1, s[17]);
        bnd();
        apb(1'b0, 12'h024, 32'h0);
        chk("bank", 32'h5, s[15:13]);
        chk("bank lines", 32'h5, rom_address_lines[15:13]);
        for (int j = 0; j < 2; j++) begin
            @(posedge pclk);
            tmr0_ack <= (j == 0);
            tmr1_ack <= (j == 1);
            n = 0;
            @(negedge pclk);
            while (int_taken === 2'h0 && n < 40) begin
                @(negedge pclk);
                n++;
            end
            chk("taken", (j == 0) ? 2'h1 : 2'h2, int_taken);
            @(posedge pclk);
            tmr0_ack <= 1'b0;
            tmr1_ack <= 1'b0;
            apb(1'b0, 12'h024, 32'h0);
            chk("vector", (j == 0) ? 16'ha008 : 16'ha00c, s[15:0]);
        end
        apb(1'b1, 12'h018, 32'h34);
        bnd();
        apb(1'b0, 12'h018, 32'h0);
        chk("low byte", 32'h34, s);
        apb(1'b0, 12'h024, 32'h0);
        chk("short jump", 32'ha034, s[15:0]);
        @(posedge pclk);
        sample_start_address <= 12'h9ab;
        wave_req <= 1'b1;
        n = 0;
        @(negedge pclk);
        while (wave_valid !== 1'b1 && n < 40) begin
            @(negedge pclk);
            n++;
        end
        chk("wave", 16'h3560 ^ 16'hc3a5, wave_data);
        @(posedge pclk);
        wave_req <= 1'b0;
        apb(1'b0, 12'h0fc, 32'h0);
        chk("unmapped", 32'h1, e);
        apb(1'b1, 12'h024, 32'hffff);
        chk("status write", 32'h1, e);
        apb(1'b0, 12'h028, 32'h0);
        chk("ctrl", 32'h1, s);
        // stopped sequencer must hold its pointer
        apb(1'b1, 12'h028, 32'h0);
        apb(1'b0, 12'h024, 32'h0);
        p0 = s[12:0];
        repeat (16) @(posedge pclk);
        apb(1'b0, 12'h024, 32'h0);
        chk("frozen", p0, s[12:0]);
        apb(1'b0, 12'h028, 32'h0);
        chk("stopped", 32'h0, s);
        do_reset();
        apb(1'b0, 12'h028, 32'h0);
        chk("ctrl reset", 32'h1, s);
        end_sim();
    end
endmodule : mcu_program_sequencer_test
